// >>> logic/slpm_consts.svh
// Purpose: Constants for the sleep and power manager
// Assumes: Included by its bare name
// Notes: Bit positions refer to the core control and clock gate registers
`ifndef SLPM_CONSTS_SVH
`define SLPM_CONSTS_SVH
`define SLPM_MODE_IDLE 2'h0
`define SLPM_MODE_NOISE 2'h1
`define SLPM_MODE_PDOWN 2'h2
`define SLPM_MODE_RSVD 2'h3
`define SLPM_CCR_BROWNOUT_SLEEP_OFF_BIT 7
`define SLPM_CCR_PERMIT_BIT 5
`define SLPM_CCR_MODE_HI 4
`define SLPM_CCR_MODE_LO 3
`define SLPM_CCR_UNLOCK_BIT 2
`define SLPM_CCR_RESET 8'h00
`define SLPM_PCG_RESET 4'h0
`define SLPM_PCG_TIM1_BIT 3
`define SLPM_PCG_TIM0_BIT 2
`define SLPM_PCG_SER_BIT 1
`define SLPM_PCG_CONV_BIT 0
`define SLPM_WAKE_HALT_CYC 16'h0004
`define SLPM_UNLOCK_WIN_CYC 3'h4
`define SLPM_BROWNOUT_SLEEP_OFF_DELAY_CYC 3'h3
`define SLPM_BROWNOUT_SLEEP_OFF_HOLD_CYC 3'h3
`endif

// >>> logic/slpm_pkg.sv
// Purpose: Types for the sleep and power manager
// Assumes: Constants live in slpm_consts.svh
// Notes: Types only
package slpm_pkg;
  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic conv;
    logic pck;
  } slpm_clk_en_t;
  typedef struct packed {
    logic ext0;
    logic pin_change;
    logic store_ready;
    logic serial_start;
    logic conv_done;
    logic other_io;
    logic watchdog_irq;
    logic ext_rst;
    logic wdt_rst;
    logic bod_rst;
  } slpm_wake_t;
  typedef enum logic [2:0] {
    SLPM_ACTIVE = 3'b001,
    SLPM_SLEEP = 3'b010,
    SLPM_WAKE = 3'b100
  } slpm_state_t;
endpackage

// >>> logic/slpm_top.sv
// Purpose: Sleep modes, clock domain gating, wake-up and brown-out control
// Assumes: Wake inputs are enabled requests on the system clock
// Notes: Core state is kept by gating clocks only
`include "slpm_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module slpm_top (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic sleep_instr_in,
  input wire logic ccr_wr_in,
  input wire logic [7:0] ccr_wdata_in,
  output logic [7:0] ccr_rdata_out,
  input wire logic pcg_wr_in,
  input wire logic [7:0] pcg_wdata_in,
  output logic [7:0] pcg_rdata_out,
  input wire slpm_pkg::slpm_wake_t wake_in,
  input wire logic ext0_level_mode_in,
  input wire logic conv_enabled_in,
  input wire logic conv_begun_in,
  input wire logic bod_fuse_enabled_in,
  input wire logic [15:0] osc_startup_cyc_in,
  input wire logic [15:0] reset_delay_cyc_in,
  input wire logic [5:0] wake_pin_mask_in,
  output slpm_pkg::slpm_clk_en_t clk_en_out,
  output logic osc_enable_out,
  output logic core_halt_out,
  output logic irq_resume_out,
  output logic reset_restart_out,
  output logic conv_start_out,
  output logic conv_extended_out,
  output logic comparator_off_out,
  output logic bod_enable_out,
  output logic [5:0] input_buf_en_out,
  output logic [3:0] periph_clk_en_out,
  output logic [3:0] periph_access_block_out
);
  import slpm_pkg::*;
  logic [1:0] rst_sync_ff;
  logic rstn;
  slpm_state_t state_ff, nxt_state;
  logic permit_ff;
  logic [1:0] mode_ff;
  logic [1:0] slept_mode_ff;
  logic [2:0] unlock_cnt_ff;
  logic [2:0] brownout_sleep_off_cnt_ff;
  logic brownout_sleep_off_active;
  logic [3:0] pcg_ff;
  logic bod_off_ff;
  logic bod_was_off_ff;
  logic wake_by_rst_ff;
  logic [15:0] wake_cnt_ff;
  logic conv_en_prev_ff;
  logic ext_conv_ff;
  logic enter_sleep;
  logic wake_hit;
  logic rst_hit;
  logic ext0_ok;
  logic [1:0] wr_mode;
  // Reset release through two flops
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rstn = rst_sync_ff[1];

  assign wr_mode = ccr_wdata_in[`SLPM_CCR_MODE_HI:`SLPM_CCR_MODE_LO];
  // Reserved mode and missing permit make sleep a no-operation
  assign enter_sleep = (state_ff == SLPM_ACTIVE) && sleep_instr_in && permit_ff &&
                       (mode_ff != `SLPM_MODE_RSVD);
  // Wake source qualification per slept mode
  assign rst_hit = wake_in.ext_rst | wake_in.wdt_rst | wake_in.bod_rst;
  assign ext0_ok = wake_in.ext0 & ext0_level_mode_in;
  always_comb begin
    wake_hit = 1'b0;
    unique case (slept_mode_ff)
      `SLPM_MODE_IDLE: wake_hit = (|wake_in);
      `SLPM_MODE_NOISE: wake_hit = rst_hit | ext0_ok | wake_in.pin_change |
        wake_in.store_ready | wake_in.serial_start | wake_in.conv_done |
        wake_in.watchdog_irq;
      `SLPM_MODE_PDOWN: wake_hit = rst_hit | ext0_ok | wake_in.pin_change |
        wake_in.serial_start | wake_in.watchdog_irq;
      default: wake_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SLPM_ACTIVE: if (enter_sleep) nxt_state = SLPM_SLEEP;
      SLPM_SLEEP: if (wake_hit) nxt_state = SLPM_WAKE;
      SLPM_WAKE: if (wake_cnt_ff == 16'h0000) nxt_state = SLPM_ACTIVE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      state_ff <= SLPM_ACTIVE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // Core control register fields
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      permit_ff <= 1'b0;
      mode_ff <= `SLPM_MODE_IDLE;
    end else if (ccr_wr_in) begin
      permit_ff <= ccr_wdata_in[`SLPM_CCR_PERMIT_BIT];
      mode_ff <= wr_mode;
    end
  end
  // Timed unlock of the brown-out sleep-off bit
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      unlock_cnt_ff <= 3'h0;
      brownout_sleep_off_cnt_ff <= 3'h0;
    end else begin
      if (ccr_wr_in && ccr_wdata_in[`SLPM_CCR_BROWNOUT_SLEEP_OFF_BIT] &&
          ccr_wdata_in[`SLPM_CCR_UNLOCK_BIT] && unlock_cnt_ff == 3'h0) begin
        unlock_cnt_ff <= `SLPM_UNLOCK_WIN_CYC;
      end else if (ccr_wr_in && unlock_cnt_ff != 3'h0 &&
                   ccr_wdata_in[`SLPM_CCR_BROWNOUT_SLEEP_OFF_BIT] &&
                   !ccr_wdata_in[`SLPM_CCR_UNLOCK_BIT]) begin
        unlock_cnt_ff <= 3'h0;
      end else if (unlock_cnt_ff != 3'h0) begin
        unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
      end
      if (ccr_wr_in && unlock_cnt_ff != 3'h0 && ccr_wdata_in[`SLPM_CCR_BROWNOUT_SLEEP_OFF_BIT] &&
          !ccr_wdata_in[`SLPM_CCR_UNLOCK_BIT]) begin
        brownout_sleep_off_cnt_ff <= `SLPM_BROWNOUT_SLEEP_OFF_DELAY_CYC + `SLPM_BROWNOUT_SLEEP_OFF_HOLD_CYC;
      end else if (brownout_sleep_off_cnt_ff != 3'h0) begin
        brownout_sleep_off_cnt_ff <= brownout_sleep_off_cnt_ff - 3'h1;
      end
    end
  end
  assign brownout_sleep_off_active = (brownout_sleep_off_cnt_ff != 3'h0) && (brownout_sleep_off_cnt_ff <= `SLPM_BROWNOUT_SLEEP_OFF_HOLD_CYC);
  // Mode latch, brown-out off in sleep, wake reason
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      slept_mode_ff <= `SLPM_MODE_IDLE;
      bod_off_ff <= 1'b0;
      bod_was_off_ff <= 1'b0;
      wake_by_rst_ff <= 1'b0;
    end else begin
      if (enter_sleep) begin
        slept_mode_ff <= mode_ff;
        bod_off_ff <= brownout_sleep_off_active && (mode_ff == `SLPM_MODE_PDOWN);
        bod_was_off_ff <= brownout_sleep_off_active && (mode_ff == `SLPM_MODE_PDOWN);
      end else if (state_ff == SLPM_SLEEP && wake_hit) begin
        bod_off_ff <= 1'b0;
        wake_by_rst_ff <= rst_hit;
      end
    end
  end
  // Wake-up halt counter
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      wake_cnt_ff <= 16'h0000;
    end else if (state_ff == SLPM_SLEEP && wake_hit) begin
      if (bod_was_off_ff) begin
        wake_cnt_ff <= reset_delay_cyc_in;
      end else if (slept_mode_ff == `SLPM_MODE_PDOWN) begin
        wake_cnt_ff <= osc_startup_cyc_in + `SLPM_WAKE_HALT_CYC;
      end else begin
        wake_cnt_ff <= `SLPM_WAKE_HALT_CYC;
      end
    end else if (wake_cnt_ff != 16'h0000) begin
      wake_cnt_ff <= wake_cnt_ff - 16'h0001;
    end
  end
  // Domain clocks; gating keeps all state intact
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      clk_en_out <= 5'h1f;
      osc_enable_out <= 1'b1;
      core_halt_out <= 1'b0;
      comparator_off_out <= 1'b0;
      input_buf_en_out <= 6'h3f;
    end else begin
      core_halt_out <= (nxt_state != SLPM_ACTIVE);
      clk_en_out.core <= (nxt_state == SLPM_ACTIVE);
      clk_en_out.flash <= (nxt_state == SLPM_ACTIVE);
      if (nxt_state == SLPM_SLEEP) begin
        unique case (state_ff == SLPM_ACTIVE ? mode_ff : slept_mode_ff)
          `SLPM_MODE_IDLE: begin
            clk_en_out.io <= 1'b1;
            clk_en_out.conv <= 1'b1;
            clk_en_out.pck <= 1'b1;
            osc_enable_out <= 1'b1;
          end
          `SLPM_MODE_NOISE: begin
            clk_en_out.io <= 1'b0;
            clk_en_out.conv <= 1'b1;
            clk_en_out.pck <= 1'b0;
            osc_enable_out <= 1'b1;
          end
          default: begin
            clk_en_out.io <= 1'b0;
            clk_en_out.conv <= 1'b0;
            clk_en_out.pck <= 1'b0;
            osc_enable_out <= 1'b0;
          end
        endcase
        comparator_off_out <= (state_ff == SLPM_ACTIVE ? mode_ff : slept_mode_ff) ==
                              `SLPM_MODE_PDOWN;
      end else begin
        clk_en_out.io <= 1'b1;
        clk_en_out.conv <= 1'b1;
        clk_en_out.pck <= 1'b1;
        osc_enable_out <= 1'b1;
        comparator_off_out <= 1'b0;
      end
      input_buf_en_out <= (nxt_state == SLPM_SLEEP &&
        (state_ff == SLPM_ACTIVE ? mode_ff : slept_mode_ff) == `SLPM_MODE_PDOWN) ?
        wake_pin_mask_in : 6'h3f;
    end
  end
  assign bod_enable_out = bod_fuse_enabled_in & ~bod_off_ff;
  // Resume and restart pulses
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      irq_resume_out <= 1'b0;
      reset_restart_out <= 1'b0;
      conv_start_out <= 1'b0;
    end else begin
      irq_resume_out <= (state_ff == SLPM_WAKE) && (wake_cnt_ff == 16'h0000) &&
                        !wake_by_rst_ff;
      reset_restart_out <= (state_ff == SLPM_WAKE) && (wake_cnt_ff == 16'h0000) &&
                           wake_by_rst_ff;
      conv_start_out <= enter_sleep && conv_enabled_in &&
                        (mode_ff != `SLPM_MODE_PDOWN);
    end
  end
  // Extended first conversion after converter off and on
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      conv_en_prev_ff <= 1'b0;
      ext_conv_ff <= 1'b1;
    end else begin
      conv_en_prev_ff <= conv_enabled_in;
      if (conv_en_prev_ff && !conv_enabled_in) begin
        ext_conv_ff <= 1'b1;
      end else if (conv_begun_in) begin
        ext_conv_ff <= 1'b0;
      end
    end
  end
  assign conv_extended_out = ext_conv_ff;
  // Peripheral clock gate register
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      pcg_ff <= `SLPM_PCG_RESET;
    end else if (pcg_wr_in) begin
      pcg_ff <= pcg_wdata_in[3:0];
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pcg
      // Timer1, timer0 and serial on io clock; converter on its own
      if (gi == `SLPM_PCG_CONV_BIT) begin : g_conv
        assign periph_clk_en_out[gi] = ~pcg_ff[gi] & clk_en_out.conv;
      end else begin : g_io
        assign periph_clk_en_out[gi] = ~pcg_ff[gi] & clk_en_out.io;
      end
      assign periph_access_block_out[gi] = pcg_ff[gi];
    end
  endgenerate

  assign pcg_rdata_out = {4'h0, pcg_ff};
  assign ccr_rdata_out = {brownout_sleep_off_active, 1'b0, permit_ff, mode_ff, unlock_cnt_ff != 3'h0, 2'h0};
  // Checks
  sequence s_enter(logic [1:0] m);
    enter_sleep && mode_ff == m;
  endsequence
  sequence s_second_write;
    ccr_wr_in && unlock_cnt_ff != 3'h0 && ccr_wdata_in[7] && !ccr_wdata_in[2];
  endsequence
  AST_IDLE: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    s_enter(2'h0) |=> !clk_en_out.core && !clk_en_out.flash && clk_en_out.io &&
    clk_en_out.pck && osc_enable_out) else $error("idle gating wrong");
  AST_NOISE: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    s_enter(2'h1) |=> !clk_en_out.io && clk_en_out.conv && osc_enable_out)
    else $error("noise gating wrong");
  AST_PDOWN: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    s_enter(2'h2) |=> !osc_enable_out && !clk_en_out.conv && comparator_off_out &&
    input_buf_en_out == $past(wake_pin_mask_in)) else $error("pdown gating wrong");
  AST_NOP: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    (state_ff == SLPM_ACTIVE && sleep_instr_in && (!permit_ff || mode_ff == 2'h3))
    |=> clk_en_out.core) else $error("sleep without permit");
  AST_HALT4: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    (state_ff == SLPM_SLEEP && wake_hit) |=> (!clk_en_out.core)[*4])
    else $error("wake halt too short");
  AST_EDGE: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    (state_ff == SLPM_SLEEP && slept_mode_ff inside {2'h1, 2'h2} && wake_in == 10'h200 &&
    !ext0_level_mode_in) |=> state_ff == SLPM_SLEEP) else $error("edge woke");
  AST_BROWNOUT_SLEEP_OFF: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    s_second_write |=> (!brownout_sleep_off_active)[*3] ##1 (brownout_sleep_off_active)[*3] ##1 !brownout_sleep_off_active)
    else $error("sleep-off timing wrong");
  AST_RST: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    reset_restart_out |-> $past(wake_by_rst_ff) && !irq_resume_out)
    else $error("restart without reset");
  AST_CONV: assert property (@(posedge ref_clk_in) disable iff (!rstn)
    (s_enter(2'h0) and conv_enabled_in) |=> conv_start_out)
    else $error("no conversion start");
endmodule
`default_nettype wire

// >>> test/slpm_conv_model.sv
// Purpose: Converter stand-in at the far side of the sleep and power manager
// Assumes: One system clock, active-low reset
// Notes: Begins a conversion one cycle after each start request made while enabled
`timescale 1ns/10ps
`default_nettype none
module slpm_conv_model (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic conv_start_in,
  input wire logic conv_enabled_in,
  output logic conv_begun_out
);
  // Start pulse only honoured while enabled
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      conv_begun_out <= 1'b0;
    end else begin
      conv_begun_out <= conv_start_in & conv_enabled_in;
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Purpose: Self-checking bench for the sleep and power manager
// Assumes: Inputs driven on the rising edge, outputs sampled 1 ns later
// Notes: Wake latencies are compared between modes
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import slpm_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic slp = 1'b0;
  logic ccr_wr = 1'b0;
  logic pcg_wr = 1'b0;
  logic lvl = 1'b0;
  logic conv_en = 1'b1;
  logic [7:0] ccr_d = 8'h00;
  logic [7:0] pcg_d = 8'h00;
  slpm_wake_t wake = '0;
  logic [7:0] ccr_q, pcg_q;
  slpm_clk_en_t clk_en;
  logic osc, halt, irq_r, rst_r, cstart, cext, cmp, bod_en, begun;
  logic [5:0] ibuf;
  logic [3:0] pclk, pblk;
  int bad_count = 0;
  int num_checks = 0;
  int n_pd = 0;
  always #10 ref_clk = ~ref_clk;
  slpm_top i_dut (.ref_clk_in(ref_clk), .rstn_in(rstn), .sleep_instr_in(slp),
    .ccr_wr_in(ccr_wr), .ccr_wdata_in(ccr_d), .ccr_rdata_out(ccr_q), .pcg_wr_in(pcg_wr),
    .pcg_wdata_in(pcg_d), .pcg_rdata_out(pcg_q), .wake_in(wake), .ext0_level_mode_in(lvl),
    .conv_enabled_in(conv_en), .conv_begun_in(begun), .bod_fuse_enabled_in(1'b1),
    .osc_startup_cyc_in(16'h0003), .reset_delay_cyc_in(16'h000a),
    .wake_pin_mask_in(6'h05), .clk_en_out(clk_en), .osc_enable_out(osc),
    .core_halt_out(halt), .irq_resume_out(irq_r), .reset_restart_out(rst_r),
    .conv_start_out(cstart), .conv_extended_out(cext), .comparator_off_out(cmp),
    .bod_enable_out(bod_en), .input_buf_en_out(ibuf), .periph_clk_en_out(pclk),
    .periph_access_block_out(pblk));
  slpm_conv_model i_conv (.ref_clk_in(ref_clk), .rstn_in(rstn), .conv_start_in(cstart),
    .conv_enabled_in(conv_en), .conv_begun_out(begun));
  task complete_run;
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task ccr_write(input logic [7:0] d);
    @(posedge ref_clk) begin ccr_wr <= 1'b1; ccr_d <= d; end
    @(posedge ref_clk) ccr_wr <= 1'b0;
    #1;
  endtask
  task pcg_write(input logic [7:0] d);
    @(posedge ref_clk) begin pcg_wr <= 1'b1; pcg_d <= d; end
    @(posedge ref_clk) pcg_wr <= 1'b0;
    #1;
  endtask
  task sleep_pulse;
    @(posedge ref_clk) slp <= 1'b1;
    @(posedge ref_clk) slp <= 1'b0;
    #1;
  endtask
  task enter(input logic [1:0] m);
    ccr_write(8'h20 | {3'h0, m, 3'h0});
    sleep_pulse;
  endtask
  task wait_wake(input logic [9:0] m, input logic ir, output int n);
    n = 0;
    @(posedge ref_clk) wake <= m;
    while (halt !== 1'b0 && n < 64) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 64) begin
      bad_count++;
      complete_run;
    end else begin
      chk(irq_r, ir);
      chk(rst_r, !ir);
      chk(clk_en, 5'h1f);
      @(posedge ref_clk) wake <= '0;
    end
  endtask
  task nowake(input logic [9:0] m);
    @(posedge ref_clk) wake <= m;
    repeat (12) @(posedge ref_clk);
    #1;
    chk(halt, 1'b1);
    @(posedge ref_clk) wake <= '0;
  endtask
  task t_reset;
    chk(clk_en, 5'h1f);
    chk({osc, halt}, 2'h2);
    chk(ccr_q, 8'h00);
    chk(pcg_q, 8'h00);
    chk(bod_en, 1'b1);
    chk(ibuf, 6'h3f);
    chk(cext, 1'b1);
  endtask
  task t_refuse;
    ccr_write(8'h10);
    sleep_pulse;
    chk({clk_en, halt}, 6'h3e);
    ccr_write(8'h38);
    sleep_pulse;
    chk({clk_en, halt}, 6'h3e);
  endtask
  task t_modes;
    logic [4:0] ce[3];
    logic [3:0] pc[3];
    int n[3];
    ce = '{5'h07, 5'h02, 5'h00};
    pc = '{4'hf, 4'h1, 4'h0};
    for (int m = 0; m < 3; m++) begin
      enter(2'(m));
      chk(clk_en, ce[m]);
      chk({osc, halt}, {m != 2, 1'b1});
      chk(cstart, m != 2);
      chk(cmp, m == 2);
      chk(ibuf, (m == 2) ? 6'h05 : 6'h3f);
      chk(pclk, pc[m]);
      wait_wake(10'h008, 1'b1, n[m]);
    end
    n_pd = n[2];
    chk(16'(n[1] - n[0]), 16'h0000);
    chk(16'(n[2] - n[0]), 16'h0003);
    chk(cext, 1'b0);
    @(posedge ref_clk) conv_en <= 1'b0;
    @(posedge ref_clk) conv_en <= 1'b1;
    #1;
    chk(cext, 1'b1);
  endtask
  task t_qualify;
    int k;
    enter(2'h1);
    nowake(10'h010);
    nowake(10'h200);
    @(posedge ref_clk) lvl <= 1'b1;
    wait_wake(10'h200, 1'b1, k);
    enter(2'h2);
    nowake(10'h080);
    nowake(10'h020);
    wait_wake(10'h040, 1'b1, k);
    enter(2'h0);
    wait_wake(10'h010, 1'b1, k);
    enter(2'h2);
    wait_wake(10'h002, 1'b0, k);
  endtask
  task t_brownout_sleep_off;
    logic [5:0] hist;
    int k;
    ccr_write(8'h84);
    ccr_write(8'h80);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      #1;
      hist[i] = ccr_q[7];
    end
    chk(hist, 6'h1c);
    ccr_write(8'h84);
    repeat (6) @(posedge ref_clk);
    ccr_write(8'h80);
    hist = '0;
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      #1;
      hist[i] = ccr_q[7];
    end
    chk(hist, 6'h00);
    ccr_write(8'hb4);
    ccr_write(8'hb0);
    k = 0;
    while (ccr_q[7] !== 1'b1 && k < 8) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 8) begin
      bad_count++;
      complete_run;
    end else begin
      sleep_pulse;
      chk(bod_en, 1'b0);
      wait_wake(10'h008, 1'b1, k);
      chk(16'(k - n_pd), 16'h0003);
      chk(bod_en, 1'b1);
    end
  endtask
  task t_gate;
    int k;
    pcg_write(8'hff);
    chk(pcg_q, 8'h0f);
    chk({pblk, pclk}, 8'hf0);
    pcg_write(8'h08);
    chk({pblk, pclk}, 8'h87);
    enter(2'h0);
    chk(pclk, 4'h7);
    wait_wake(10'h008, 1'b1, k);
    pcg_write(8'h00);
    chk({pblk, pclk}, 8'h0f);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    t_reset;
    t_refuse;
    t_modes;
    t_qualify;
    t_brownout_sleep_off;
    t_gate;
    complete_run;
  end
endmodule
`default_nettype wire
